// *** rtl/tvlr_top.sv ***
// typed value latch register: float, signed long and word variants
`timescale 1ns/1ns
`default_nettype none

//////////////////////////////////////////////////////////////////////////
// Overview of operation
// - float variant stores and outputs 32-bit float
// - long variant holds and outputs signed 32-bit
// - high mode loads while latch is one
// - low mode loads while latch is zero
// - unconnected latch reads as zero
// - rise mode captures on low-to-high latch
// - fall mode captures on high-to-low latch
// - both mode captures on any latch change
// - startup loads configurable initial value, default zero
// - persistence restores saved value after power
// - new program picks initial or saved value
// - other input types convert to float on capture
// - word variant holds 16-bit unsigned, same modes
//////////////////////////////////////////////////////////////////////////

module tvlr_top (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [31:0] data_in,
  input  wire logic [1:0]  data_type,
  input  wire logic        lat,
  input  wire logic        lat_connected,
  input  wire logic [2:0]  edge_mode,
  input  wire logic [31:0] init_float,
  input  wire logic [31:0] init_long,
  input  wire logic [15:0] init_word,
  input  wire logic        persist_en,
  input  wire logic        load_init_sel,
  input  wire logic        program_new,
  input  wire logic        nv_valid,
  input  wire logic [31:0] nv_float,
  input  wire logic [31:0] nv_long,
  input  wire logic [15:0] nv_word,
  output logic [31:0]      float_value_out,
  output logic [31:0]      signed_value_out,
  output logic [15:0]      unsigned_word_out,
  output logic             nv_write,
  output logic             ready
);

  //////////////////////////////////////////////////////////////////////
  // conversion helpers

  // signed integer to single precision, truncating low bits
  function automatic logic [31:0] tvlr_i2f(input logic [31:0] x);
    logic [31:0] mag;
    logic [31:0] nrm;
    logic [7:0]  expo;
    logic [4:0]  msb;
    mag = x[31] ? (~x + 32'h0000_0001) : x;
    msb = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (mag[i]) begin
        msb = 5'(i);
      end
    end
    nrm  = mag << (5'h1f - msb);
    expo = tvlr_pkg::FLT_BIAS + {3'h0, msb};
    return (mag == 32'h0000_0000) ? tvlr_pkg::RST_VAL : {x[31], expo, nrm[30:8]};
  endfunction

  // single precision to signed integer, toward zero, saturating
  function automatic logic [31:0] tvlr_f2i(input logic [31:0] f);
    logic [7:0]  expo;
    logic [31:0] man;
    logic [31:0] res;
    expo = f[tvlr_pkg::FLT_EXP_H:tvlr_pkg::FLT_EXP_L];
    man  = {9'h001, f[tvlr_pkg::FLT_MAN_H:0]};
    res  = 32'h0000_0000;
    if (expo < tvlr_pkg::FLT_BIAS) begin
      res = 32'h0000_0000;
    end else if (expo >= tvlr_pkg::FLT_OVER) begin
      res = f[tvlr_pkg::FLT_SIGN] ? tvlr_pkg::LONG_MIN : tvlr_pkg::LONG_MAX;
    end else begin
      if (expo >= tvlr_pkg::FLT_EXACT) begin
        res = man << (expo - tvlr_pkg::FLT_EXACT);
      end else begin
        res = man >> (tvlr_pkg::FLT_EXACT - expo);
      end
      if (f[tvlr_pkg::FLT_SIGN]) begin
        res = ~res + 32'h0000_0001;
      end
    end
    return res;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // declarations

  tvlr_pkg::tvlr_state_t state_q;
  tvlr_pkg::tvlr_state_t state_d;

  logic [31:0] float_q;
  logic [31:0] float_d;
  logic [31:0] long_q;
  logic [31:0] long_d;
  logic [15:0] word_q;
  logic [15:0] word_d;
  logic        nv_write_q;
  logic        nv_write_d;
  logic        ready_q;

  logic        lat_eff;
  logic        cap_en;
  logic        in_boot;
  logic        in_run;
  logic        use_nv;
  logic        take;
  logic        is_float;
  logic [31:0] src_long;
  logic [31:0] conv_float;
  logic [31:0] conv_long;
  logic [15:0] conv_word;
  logic [31:0] boot_float;
  logic [31:0] boot_long;
  logic [15:0] boot_word;

  //////////////////////////////////////////////////////////////////////
  // latch control

  // a missing latch wire behaves as logic zero
  assign lat_eff = lat & lat_connected;

  tvlr_latch_cond u_cond (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .lat_eff   (lat_eff),
    .edge_mode (edge_mode),
    .cap_en    (cap_en)
  );

  //////////////////////////////////////////////////////////////////////
  // input type casting

  assign is_float = (data_type == tvlr_pkg::TYPE_FLOAT);

  assign src_long = (data_type == tvlr_pkg::TYPE_BOOL) ? {31'h0000_0000, data_in[0]} :
                    (data_type == tvlr_pkg::TYPE_WORD) ? {16'h0000, data_in[15:0]} :
                    data_in;

  assign conv_float = is_float ? data_in : tvlr_i2f(src_long);
  assign conv_long  = is_float ? tvlr_f2i(data_in) : src_long;
  // word keeps the low half of the integer value
  assign conv_word  = conv_long[15:0];

  //////////////////////////////////////////////////////////////////////
  // startup value source

  // saved value when persistence is on and it is valid, unless a fresh program asks for initial values
  assign use_nv = persist_en & nv_valid & ~(program_new & load_init_sel);

  assign boot_float = use_nv ? nv_float : init_float;
  assign boot_long  = use_nv ? nv_long : init_long;
  assign boot_word  = use_nv ? nv_word : init_word;

  //////////////////////////////////////////////////////////////////////
  // sequencing

  assign in_boot = (state_q == tvlr_pkg::ST_BOOT);
  assign in_run  = (state_q == tvlr_pkg::ST_RUN);
  assign take    = in_run & cap_en;

  always_comb begin
    state_d = state_q;
    case (state_q)
      tvlr_pkg::ST_BOOT: begin
        state_d = tvlr_pkg::ST_RUN;
      end
      tvlr_pkg::ST_RUN: begin
        state_d = tvlr_pkg::ST_RUN;
      end
      default: begin
        state_d = tvlr_pkg::ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= tvlr_pkg::ST_BOOT;
    end else begin
      state_q <= state_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register next values

  assign float_d = in_boot ? boot_float : (take ? conv_float : float_q);
  assign long_d  = in_boot ? boot_long : (take ? conv_long : long_q);
  assign word_d  = in_boot ? boot_word : (take ? conv_word : word_q);

  // with persistence enabled, every capture is handed to the non-volatile store
  assign nv_write_d = take & persist_en;

  //////////////////////////////////////////////////////////////////////
  // storage

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      float_q <= tvlr_pkg::RST_VAL;
    end else begin
      float_q <= float_d;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      long_q <= tvlr_pkg::RST_VAL;
    end else begin
      long_q <= long_d;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      word_q <= tvlr_pkg::RST_WORD;
    end else begin
      word_q <= word_d;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      nv_write_q <= 1'b0;
      ready_q    <= 1'b0;
    end else begin
      nv_write_q <= nv_write_d;
      ready_q    <= in_boot | in_run;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign float_value_out   = float_q;
  assign signed_value_out  = long_q;
  assign unsigned_word_out = word_q;
  assign nv_write          = nv_write_q;
  assign ready             = ready_q;

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_float_store_out: assert property (
    in_run && cap_en && is_float |=> float_value_out == $past(data_in))
    else $error("float capture not on output");

  a_long_change_cause: assert property (
    $changed(signed_value_out) |-> $past(take) || $past(in_boot))
    else $error("long output changed without cause");

  a_high_mode_load: assert property (
    in_run && edge_mode == tvlr_pkg::MODE_HIGH && lat_eff
    |=> signed_value_out == $past(conv_long))
    else $error("high mode did not load");

  a_low_mode_load: assert property (
    in_run && edge_mode == tvlr_pkg::MODE_LOW && !lat
    |=> float_value_out == $past(conv_float))
    else $error("low mode did not load");

  a_unconn_follow: assert property (
    in_run && edge_mode == tvlr_pkg::MODE_LOW && !lat_connected
    |=> unsigned_word_out == $past(conv_word))
    else $error("unconnected latch did not follow");

  a_boot_init_val: assert property (
    in_boot && !persist_en
    |=> signed_value_out == $past(init_long) && unsigned_word_out == $past(init_word))
    else $error("startup initial value not loaded");

  a_nv_restore_val: assert property (
    in_boot && persist_en && nv_valid && !program_new
    |=> float_value_out == $past(nv_float))
    else $error("saved value not restored");

  a_new_prog_init: assert property (
    in_boot && program_new && load_init_sel
    |=> float_value_out == $past(init_float))
    else $error("new program ignored initial value");

  a_bool_to_float: assert property (
    take && data_type == tvlr_pkg::TYPE_BOOL
    |=> float_value_out == ($past(data_in[0]) ? tvlr_pkg::FLT_ONE : tvlr_pkg::RST_VAL))
    else $error("boolean to float cast wrong");

  a_word_low_half: assert property (
    take && data_type == tvlr_pkg::TYPE_LONG
    |=> unsigned_word_out == $past(data_in[15:0]))
    else $error("word cast did not keep low half");

  a_hold_unmet: assert property (
    in_run && !cap_en
    |=> $stable(float_value_out) && $stable(signed_value_out) && $stable(unsigned_word_out))
    else $error("value changed without capture");

  a_nv_write_pulse: assert property (
    take && persist_en |=> nv_write && signed_value_out == $past(conv_long))
    else $error("save strobe wrong");

  a_nv_write_idle: assert property (
    !(take && persist_en) |=> !nv_write)
    else $error("save strobe without capture");

  a_ready_in_run: assert property (
    in_run |-> ready)
    else $error("ready low after startup");

  a_rise_mode_load: assert property (
    in_run && edge_mode == tvlr_pkg::MODE_RISE && cap_en
    |=> signed_value_out == $past(conv_long))
    else $error("rise mode did not load");

  a_both_mode_load: assert property (
    in_run && edge_mode == tvlr_pkg::MODE_BOTH && cap_en
    |=> unsigned_word_out == $past(conv_word))
    else $error("both mode did not load");

  c_rise_capture: cover property (
    in_run && edge_mode == tvlr_pkg::MODE_RISE && $rose(lat_eff) ##1 $changed(signed_value_out));

  c_fall_capture: cover property (
    in_run && edge_mode == tvlr_pkg::MODE_FALL && $fell(lat_eff));

  c_nv_boot: cover property (
    in_boot && use_nv);

  c_low_follow: cover property (
    (in_run && edge_mode == tvlr_pkg::MODE_LOW && !lat_connected) [*3]);

  c_both_capture: cover property (
    in_run && edge_mode == tvlr_pkg::MODE_BOTH && $fell(lat_eff) ##1 $changed(unsigned_word_out));

endmodule

`default_nettype wire

// *** include/tvlr_pkg.sv ***
// constants and types shared by the typed value latch register
package tvlr_pkg;

  localparam int unsigned VAL_W  = 32;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned MODE_W = 3;
  localparam int unsigned TYPE_W = 2;

  // edge type codes
  localparam logic [2:0] MODE_HIGH = 3'h0;
  localparam logic [2:0] MODE_LOW  = 3'h1;
  localparam logic [2:0] MODE_RISE = 3'h2;
  localparam logic [2:0] MODE_FALL = 3'h3;
  localparam logic [2:0] MODE_BOTH = 3'h4;

  // data input type codes
  localparam logic [1:0] TYPE_BOOL  = 2'h0;
  localparam logic [1:0] TYPE_WORD  = 2'h1;
  localparam logic [1:0] TYPE_LONG  = 2'h2;
  localparam logic [1:0] TYPE_FLOAT = 2'h3;

  // reset values
  localparam logic [31:0] RST_VAL  = 32'h0000_0000;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // single precision layout
  localparam int unsigned FLT_SIGN  = 31;
  localparam int unsigned FLT_EXP_H = 30;
  localparam int unsigned FLT_EXP_L = 23;
  localparam int unsigned FLT_MAN_H = 22;
  localparam logic [7:0]  FLT_BIAS  = 8'h7f;
  localparam logic [7:0]  FLT_EXACT = 8'h96;
  localparam logic [7:0]  FLT_OVER  = 8'h9e;
  localparam logic [31:0] FLT_ONE   = 32'h3f80_0000;

  // signed integer limits
  localparam logic [31:0] LONG_MAX = 32'h7fff_ffff;
  localparam logic [31:0] LONG_MIN = 32'h8000_0000;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b01,
    ST_RUN  = 2'b10
  } tvlr_state_t;

endpackage

// *** rtl/tvlr_latch_cond.sv ***
// latch condition decoder with previous-cycle edge detection
`timescale 1ns/1ns
`default_nettype none

module tvlr_latch_cond (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       lat_eff,
  input  wire logic [2:0] edge_mode,
  output logic            cap_en
);

  logic lat_prev_q;
  logic lat_rise;
  logic lat_fall;
  logic sel_high;
  logic sel_low;
  logic sel_rise;
  logic sel_fall;
  logic sel_both;

  //////////////////////////////////////////////////////////////////////
  // previous scan sample
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lat_prev_q <= 1'b0;
    end else begin
      lat_prev_q <= lat_eff;
    end
  end

  assign lat_rise = lat_eff & ~lat_prev_q;
  assign lat_fall = ~lat_eff & lat_prev_q;

  assign sel_high = (edge_mode == tvlr_pkg::MODE_HIGH) & lat_eff;
  assign sel_low  = (edge_mode == tvlr_pkg::MODE_LOW) & ~lat_eff;
  assign sel_rise = (edge_mode == tvlr_pkg::MODE_RISE) & lat_rise;
  assign sel_fall = (edge_mode == tvlr_pkg::MODE_FALL) & lat_fall;
  assign sel_both = (edge_mode == tvlr_pkg::MODE_BOTH) & (lat_rise | lat_fall);

  // unknown codes never capture
  assign cap_en = sel_high | sel_low | sel_rise | sel_fall | sel_both;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_rise_only_cap: assert property (
    edge_mode == tvlr_pkg::MODE_RISE |-> cap_en == $rose(lat_eff))
    else $error("rise mode capture mismatch");

  a_fall_only_cap: assert property (
    edge_mode == tvlr_pkg::MODE_FALL |-> cap_en == $fell(lat_eff))
    else $error("fall mode capture mismatch");

  a_both_edge_cap: assert property (
    edge_mode == tvlr_pkg::MODE_BOTH |-> cap_en == $changed(lat_eff))
    else $error("both edge capture mismatch");

  a_prev_edge_track: assert property (
    lat_eff [*2] |-> !(cap_en && edge_mode == tvlr_pkg::MODE_RISE))
    else $error("steady high seen as edge");

endmodule

`default_nettype wire

// *** verification/tvlr_src.sv ***
// upstream source model: data and latch control
`timescale 1ns/1ns
`default_nettype none

module tvlr_src (
  input  wire logic        mclk,
  output var  logic [31:0] data_in,
  output var  logic [1:0]  data_type,
  output var  logic        lat,
  output var  logic        lat_connected
);
  initial begin
    data_in = 32'h0000_0000;
    data_type = tvlr_pkg::TYPE_LONG;
    lat = 1'b0;
    lat_connected = 1'b1;
  end

  // new values just after an edge, held until the next call
  task automatic put(input logic l, input logic [31:0] d, input logic [1:0] t, input logic c);
    @(posedge mclk);
    lat <= l;
    data_in <= d;
    data_type <= t;
    lat_connected <= c;
  endtask
endmodule

`default_nettype wire

// *** verification/tvlr_top_tb.sv ***
// self-checking bench for the typed value latch register
`timescale 1ns/1ns
`default_nettype none

module tvlr_top_tb;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  edge_mode = tvlr_pkg::MODE_HIGH;
  logic [31:0] init_float = 32'h0000_0000;
  logic [31:0] init_long = 32'h0000_0000;
  logic [15:0] init_word = 16'h0000;
  logic        persist_en = 1'b0;
  logic        load_init_sel = 1'b0;
  logic        program_new = 1'b0;
  logic        nv_valid = 1'b0;
  logic [31:0] nv_float = 32'h4188_0000;
  logic [31:0] nv_long = 32'h0000_0011;
  logic [15:0] nv_word = 16'h0011;
  wire  [31:0] data_in;
  wire  [1:0]  data_type;
  wire         lat;
  wire         lat_connected;
  wire  [31:0] float_value_out;
  wire  [31:0] signed_value_out;
  wire  [15:0] unsigned_word_out;
  wire         nv_write;
  wire         ready;
  int          fails = 0;
  int          checked = 0;
  int          cycles = 0;

  always #25 mclk = ~mclk;

  tvlr_src u_src (
    .mclk          (mclk),
    .data_in       (data_in),
    .data_type     (data_type),
    .lat           (lat),
    .lat_connected (lat_connected)
  );

  tvlr_top u_dut (
    .mclk              (mclk),
    .reset_n           (reset_n),
    .data_in           (data_in),
    .data_type         (data_type),
    .lat               (lat),
    .lat_connected     (lat_connected),
    .edge_mode         (edge_mode),
    .init_float        (init_float),
    .init_long         (init_long),
    .init_word         (init_word),
    .persist_en        (persist_en),
    .load_init_sel     (load_init_sel),
    .program_new       (program_new),
    .nv_valid          (nv_valid),
    .nv_float          (nv_float),
    .nv_long           (nv_long),
    .nv_word           (nv_word),
    .float_value_out   (float_value_out),
    .signed_value_out  (signed_value_out),
    .unsigned_word_out (unsigned_word_out),
    .nv_write          (nv_write),
    .ready             (ready)
  );

  //////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      wrap_up();
    end
  end

  // expected capture condition per edge mode
  function automatic logic hit(input logic [2:0] m, input logic l, input logic p);
    case (m)
      tvlr_pkg::MODE_HIGH: hit = l;
      tvlr_pkg::MODE_LOW:  hit = !l;
      tvlr_pkg::MODE_RISE: hit = l & !p;
      tvlr_pkg::MODE_FALL: hit = !l & p;
      tvlr_pkg::MODE_BOTH: hit = l ^ p;
      default:             hit = 1'b0;
    endcase
  endfunction

  task automatic do_reset();
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    chk("reset float", 32'h0, float_value_out);
    chk("reset ready", 32'h0, {31'h0, ready});
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask

  //////////////////////////////////////////////////////////////////////
  // latch pattern 0,1,1,0,0,1,0,1,0 with a new value each cycle
  task automatic mode_run(input logic [2:0] m, input logic c);
    logic [8:0]  sq;
    logic [31:0] ex;
    logic [31:0] pd;
    logic        pl;
    logic        pp;
    sq = 9'h0a6;
    ex = 32'h0;
    pd = 32'h0;
    pl = 1'b0;
    pp = 1'b0;
    edge_mode <= m;
    u_src.put(1'b0, 32'h0, tvlr_pkg::TYPE_LONG, c);
    do_reset();
    for (int i = 0; i < 9; i++) begin
      u_src.put(sq[i], 32'(i + 1), tvlr_pkg::TYPE_LONG, c);
      if (hit(m, pl & c, pp))
        ex = pd;
      pp = pl & c;
      pl = sq[i];
      pd = 32'(i + 1);
      #1 chk("mode long", ex, signed_value_out);
    end
  endtask

  task automatic conv(input logic [1:0] t, input logic [31:0] d, input logic [31:0] ef,
                      input logic [31:0] el, input logic [15:0] ew);
    u_src.put(1'b1, d, t, 1'b1);
    u_src.put(1'b0, 32'h0, t, 1'b1);
    #1;
    chk("conv float", ef, float_value_out);
    chk("conv long", el, signed_value_out);
    chk("conv word", {16'h0, ew}, {16'h0, unsigned_word_out});
    chk("nv pulse", 32'h1, {31'h0, nv_write});
    @(posedge mclk);
    #1 chk("nv pulse end", 32'h0, {31'h0, nv_write});
  endtask

  task automatic boot(input logic pe, input logic pn, input logic lis, input logic use_nv);
    persist_en <= pe;
    program_new <= pn;
    load_init_sel <= lis;
    do_reset();
    #1;
    chk("boot long", use_nv ? 32'h11 : 32'h7, signed_value_out);
    chk("boot float", use_nv ? 32'h4188_0000 : 32'h40e0_0000, float_value_out);
    chk("boot word", use_nv ? 32'h11 : 32'h7, {16'h0, unsigned_word_out});
    chk("ready", 32'h1, {31'h0, ready});
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    mode_run(tvlr_pkg::MODE_HIGH, 1'b1);
    mode_run(tvlr_pkg::MODE_LOW, 1'b1);
    mode_run(tvlr_pkg::MODE_RISE, 1'b1);
    mode_run(tvlr_pkg::MODE_FALL, 1'b1);
    mode_run(tvlr_pkg::MODE_BOTH, 1'b1);
    mode_run(3'h5, 1'b1);
    mode_run(tvlr_pkg::MODE_LOW, 1'b0);
    mode_run(tvlr_pkg::MODE_RISE, 1'b0);
    edge_mode <= tvlr_pkg::MODE_HIGH;
    persist_en <= 1'b1;
    do_reset();
    conv(tvlr_pkg::TYPE_LONG, 32'h0001_3880, 32'h479c_4000, 32'h0001_3880, 16'h3880);
    conv(tvlr_pkg::TYPE_FLOAT, 32'h4145_70a4, 32'h4145_70a4, 32'h0000_000c, 16'h000c);
    conv(tvlr_pkg::TYPE_FLOAT, 32'h42c5_cccd, 32'h42c5_cccd, 32'h0000_0062, 16'h0062);
    conv(tvlr_pkg::TYPE_WORD, 32'h0000_000c, 32'h4140_0000, 32'h0000_000c, 16'h000c);
    conv(tvlr_pkg::TYPE_BOOL, 32'h0000_0001, 32'h3f80_0000, 32'h0000_0001, 16'h0001);
    conv(tvlr_pkg::TYPE_LONG, 32'hffff_fffb, 32'hc0a0_0000, 32'hffff_fffb, 16'hfffb);
    init_float <= 32'h40e0_0000;
    init_long <= 32'h0000_0007;
    init_word <= 16'h0007;
    nv_valid <= 1'b1;
    boot(1'b0, 1'b0, 1'b0, 1'b0);
    boot(1'b1, 1'b0, 1'b0, 1'b1);
    boot(1'b1, 1'b1, 1'b1, 1'b0);
    boot(1'b1, 1'b1, 1'b0, 1'b1);
    boot(1'b0, 1'b1, 1'b0, 1'b0);
    wrap_up();
  end
endmodule

`default_nettype wire
